// >>> verilog/mx_exec_regs.svh
/*
 * Constants for the instruction execute subset: sizes, reset values,
 * decimal adjust figures and timing counts.
 * Assumes it is included by bare name wherever these are needed.
 */
`ifndef MX_EXEC_REGS_SVH
`define MX_EXEC_REGS_SVH

// sizes
`define MX_DATA_W        8
`define MX_PC_W          12
`define MX_MEM_DEPTH     192
`define MX_MEM_AW        8
`define MX_STACK_DEPTH   8
`define MX_STACK_PW      3

// reset values
`define MX_PC_RST        12'h000
`define MX_ACC_RST       8'h00
`define MX_GIE_RST       1'b0
`define MX_PDF_RST       1'b0
`define MX_TOF_RST       1'b0

// decimal adjust
`define MX_BCD_ADJ       4'h6
`define MX_BCD_MAX       5'h09

// cycles taken by the three return instructions
`define MX_EXIT_CYCLES   2

`endif

// >>> verilog/mx_pkg.sv
/*
 * Types for the instruction execute subset: the operation code and the sequencer state.
 * Assumes nothing beyond the constants header.
 */
package mx_pkg;

    // operations carried out by this block
    typedef enum logic [4:0] {
        OP_IDLE,
        OP_WATCHDOG_CLEAR,
        OP_PRECLEAR_FIRST,
        OP_PRECLEAR_SECOND,
        OP_COMPLEMENT,
        OP_COMPLEMENT_TO_WORKING,
        OP_DECIMAL_ADJUST,
        OP_MINUS_ONE,
        OP_MINUS_ONE_TO_WORKING,
        OP_PLUS_ONE,
        OP_PLUS_ONE_TO_WORKING,
        OP_HALT,
        OP_JUMP,
        OP_COPY_IMM,
        OP_COPY_FROM_MEM,
        OP_COPY_TO_MEM,
        OP_UNION_IMM,
        OP_UNION_MEM,
        OP_UNION_TO_MEMORY,
        OP_SUBROUTINE_EXIT,
        OP_SUBROUTINE_EXIT_CONST,
        OP_INTERRUPT_EXIT,
        OP_ROTATE_LEFT,
        OP_ROTATE_LEFT_TO_WORKING
    } mx_op_e;

    // sequencer states
    typedef enum logic {
        ST_RUN,
        ST_EXIT_WAIT
    } mx_state_e;

endpackage

// >>> verilog/mx_alu.sv
/*
 * Data path of the execute subset: result byte, destinations and flags.
 * Assumes the caller supplies the addressed memory byte combinationally.
 */
`timescale 1ns/1ps
`include "mx_exec_regs.svh"

module mx_alu (
    input  mx_pkg::mx_op_e             op,
    input  wire logic [7:0]            working,
    input  wire logic [7:0]            mem_data,
    input  wire logic [7:0]            imm,
    input  wire logic                  carry,
    input  wire logic                  aux_carry,
    output logic      [7:0]            result,
    output logic                       to_working,
    output logic                       to_memory,
    output logic                       sets_zero,
    output logic                       sets_carry,
    output logic                       carry_out
);

    logic       adj_low;
    logic       low_nibble_adjust_carry;
    logic [4:0] high_sum;
    logic       adj_high;
    logic [3:0] low_res;
    logic [3:0] high_res;

    // decimal adjust of the working register
    always_comb
    begin
        adj_low = (5'(working[3:0]) > `MX_BCD_MAX) || aux_carry;
        low_nibble_adjust_carry = adj_low & ~aux_carry;
        low_res = adj_low ? working[3:0] + `MX_BCD_ADJ : working[3:0];
        high_sum = 5'(working[7:4]) + 5'(low_nibble_adjust_carry);
        adj_high = (high_sum > `MX_BCD_MAX) || carry;
        high_res = adj_high ? high_sum[3:0] + `MX_BCD_ADJ : high_sum[3:0];
    end

    // result and destination per operation
    always_comb
    begin
        result = working;
        to_working = 1'b0;
        to_memory = 1'b0;
        sets_zero = 1'b0;
        sets_carry = 1'b0;
        carry_out = carry;
        unique case (op)
            mx_pkg::OP_COMPLEMENT:
            begin
                result = ~mem_data;
                to_memory = 1'b1;
                sets_zero = 1'b1;
            end
            mx_pkg::OP_COMPLEMENT_TO_WORKING:
            begin
                result = ~mem_data;
                to_working = 1'b1;
                sets_zero = 1'b1;
            end
            mx_pkg::OP_DECIMAL_ADJUST:
            begin
                result = {high_res, low_res};
                to_memory = 1'b1;
                sets_carry = 1'b1;
                carry_out = adj_high | carry;
            end
            mx_pkg::OP_MINUS_ONE, mx_pkg::OP_MINUS_ONE_TO_WORKING:
            begin
                result = mem_data - 8'h01;
                to_memory = (op == mx_pkg::OP_MINUS_ONE);
                to_working = (op == mx_pkg::OP_MINUS_ONE_TO_WORKING);
                sets_zero = 1'b1;
            end
            mx_pkg::OP_PLUS_ONE, mx_pkg::OP_PLUS_ONE_TO_WORKING:
            begin
                result = mem_data + 8'h01;
                to_memory = (op == mx_pkg::OP_PLUS_ONE);
                to_working = (op == mx_pkg::OP_PLUS_ONE_TO_WORKING);
                sets_zero = 1'b1;
            end
            mx_pkg::OP_COPY_IMM, mx_pkg::OP_SUBROUTINE_EXIT_CONST:
            begin
                result = imm;
                to_working = 1'b1;
            end
            mx_pkg::OP_COPY_FROM_MEM:
            begin
                result = mem_data;
                to_working = 1'b1;
            end
            mx_pkg::OP_COPY_TO_MEM:
            begin
                result = working;
                to_memory = 1'b1;
            end
            mx_pkg::OP_UNION_IMM:
            begin
                result = working | imm;
                to_working = 1'b1;
                sets_zero = 1'b1;
            end
            mx_pkg::OP_UNION_MEM, mx_pkg::OP_UNION_TO_MEMORY:
            begin
                result = working | mem_data;
                to_working = (op == mx_pkg::OP_UNION_MEM);
                to_memory = (op == mx_pkg::OP_UNION_TO_MEMORY);
                sets_zero = 1'b1;
            end
            mx_pkg::OP_ROTATE_LEFT, mx_pkg::OP_ROTATE_LEFT_TO_WORKING:
            begin
                result = {mem_data[6:0], mem_data[7]};
                to_memory = (op == mx_pkg::OP_ROTATE_LEFT);
                to_working = (op == mx_pkg::OP_ROTATE_LEFT_TO_WORKING);
            end
            default:
            begin
                result = working;
            end
        endcase
    end

endmodule

// >>> verilog/mx_stack.sv
/*
 * Return address stack of eight entries, circular on over- and underflow.
 * Assumes push and pop never come in the same cycle.
 */
`timescale 1ns/1ps
`include "mx_exec_regs.svh"

module mx_stack (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  push,
    input  wire logic [`MX_PC_W-1:0]   push_data,
    input  wire logic                  pop,
    output logic      [`MX_PC_W-1:0]   top
);

    logic [`MX_PC_W-1:0]    entry [`MX_STACK_DEPTH];
    logic [`MX_STACK_PW-1:0] ptr;
    logic [`MX_STACK_PW-1:0] top_idx;

    assign top_idx = ptr - 3'd1;
    assign top = entry[top_idx];

    // stack pointer
    always_ff @(posedge clk)
    begin
        if (rst)
            ptr <= '0;
        else if (push)
            ptr <= ptr + 3'd1;
        else if (pop)
            ptr <= top_idx;
    end

    // entry storage, written at the pointer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `MX_STACK_DEPTH; i++)
                entry[i] <= `MX_PC_RST;
        end
        else if (push)
            entry[ptr] <= push_data;
    end

endmodule

// >>> verilog/mx_exec_core.sv
/*
 * Execute stage for a subset of an 8-bit microcontroller instruction set:
 * working register, data memory, program counter, stack and the
 * timeout, power-down and interrupt-enable flags.
 * Assumes decoded instructions arrive as opcode plus operands, synchronous
 * to clk; the watchdog counter, prescaler and interrupt controller sit
 * outside and follow the clear pulses and flag outputs given here.
 */
// Overview of operation
// - watchdog clear resets counter, clears timeout and power-down flags
// - both preclears executed: reset counter, clear timeout and power-down
// - one preclear alone only records itself; counter and flags unchanged
// - complement inverts addressed byte, writes it back, updates zero only
// - complement-to-working puts inverted byte in working, memory untouched
// - decimal adjust adds 6 to low nibble above 9 or aux carry
// - high nibble plus internal carry adjusted likewise; sets carry; to memory
// - decrement subtracts one, zero flag only, to memory or working
// - increment adds one, zero flag only, to memory or working
// - halt advances counter, stops execution, gates clock, keeps contents
// - halt clears watchdog and prescaler, sets power-down, clears timeout
// - jump loads program counter with address, flags untouched
// - immediate copy loads 8-bit constant into working, flags untouched
// - copies move byte between memory and working, no flag affected
// - idle only advances program counter, changes nothing else
// - union ORs working with memory or constant, zero flag only
// - subroutine exit pops program counter, takes two cycles, flags untouched
// - exit with constant pops counter and loads constant into working
// - interrupt exit pops counter and sets global interrupt enable
// - rotate left moves bit 7 to bit 0, writes back, no flags
// - rotate-left-to-working puts result in working, memory unchanged
`timescale 1ns/1ps
`include "mx_exec_regs.svh"

module mx_exec_core (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  instr_valid,
    input  mx_pkg::mx_op_e             opcode,
    input  wire logic [`MX_MEM_AW-1:0] mem_addr,
    input  wire logic [7:0]            imm,
    input  wire logic [`MX_PC_W-1:0]   jump_addr,
    input  wire logic                  push_valid,
    input  wire logic [`MX_PC_W-1:0]   push_addr,
    input  wire logic                  flags_load,
    input  wire logic [2:0]            flags_load_data,
    input  wire logic                  timeout_event,
    input  wire logic                  interrupt_taken,
    input  wire logic                  wake,
    input  wire logic [`MX_MEM_AW-1:0] peek_addr,
    output logic                       busy,
    output logic                       halted,
    output logic                       sys_clock_enable,
    output logic      [`MX_PC_W-1:0]   pc,
    output logic      [7:0]            working,
    output logic                       zero_flag,
    output logic                       carry_flag,
    output logic                       aux_carry_flag,
    output logic                       watchdog_timeout_flag,
    output logic                       powerdown_flag,
    output logic                       global_interrupt_enable,
    output logic                       watchdog_clear,
    output logic                       prescaler_clear,
    output logic      [7:0]            peek_data
);

    mx_pkg::mx_state_e   state;
    logic [7:0]          mem [`MX_MEM_DEPTH];
    logic                take;
    logic [7:0]          mem_rd;
    logic [7:0]          alu_result;
    logic                alu_to_working;
    logic                alu_to_memory;
    logic                alu_sets_zero;
    logic                alu_sets_carry;
    logic                alu_carry_out;
    logic [`MX_PC_W-1:0] stack_top;
    logic                is_exit;
    logic                first_seen;
    logic                second_seen;
    logic                pair_done;
    logic                wd_clear_now;

    // an instruction is taken only while running and not halted
    assign take = instr_valid && !busy && !halted;
    assign is_exit = (opcode == mx_pkg::OP_SUBROUTINE_EXIT)
                  || (opcode == mx_pkg::OP_SUBROUTINE_EXIT_CONST)
                  || (opcode == mx_pkg::OP_INTERRUPT_EXIT);
    assign mem_rd = (mem_addr < 8'(`MX_MEM_DEPTH)) ? mem[mem_addr] : 8'h00;

    // preclear pairing: second of the pair completes the clear
    assign pair_done = take
        && (((opcode == mx_pkg::OP_PRECLEAR_FIRST) && second_seen)
         || ((opcode == mx_pkg::OP_PRECLEAR_SECOND) && first_seen));
    assign wd_clear_now = pair_done
        || (take && (opcode == mx_pkg::OP_WATCHDOG_CLEAR));

    mx_alu u_alu (
        .op         (opcode),
        .working    (working),
        .mem_data   (mem_rd),
        .imm        (imm),
        .carry      (carry_flag),
        .aux_carry  (aux_carry_flag),
        .result     (alu_result),
        .to_working (alu_to_working),
        .to_memory  (alu_to_memory),
        .sets_zero  (alu_sets_zero),
        .sets_carry (alu_sets_carry),
        .carry_out  (alu_carry_out)
    );

    mx_stack u_stack (
        .clk       (clk),
        .rst       (rst),
        .push      (push_valid && !take),
        .push_data (push_addr),
        .pop       (take && is_exit),
        .top       (stack_top)
    );

    // two-cycle returns: second cycle holds off the next instruction
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= mx_pkg::ST_RUN;
            busy <= 1'b0;
        end
        else
        begin
            unique case (state)
                mx_pkg::ST_RUN:
                    if (take && is_exit)
                    begin
                        state <= mx_pkg::ST_EXIT_WAIT;
                        busy <= 1'b1;
                    end
                mx_pkg::ST_EXIT_WAIT:
                begin
                    state <= mx_pkg::ST_RUN;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // program counter
    always_ff @(posedge clk)
    begin
        if (rst)
            pc <= `MX_PC_RST;
        else if (take)
        begin
            if (opcode == mx_pkg::OP_JUMP)
                pc <= jump_addr;
            else if (is_exit)
                pc <= stack_top;
            else
                pc <= pc + 12'h001;
        end
    end

    // working register
    always_ff @(posedge clk)
    begin
        if (rst)
            working <= `MX_ACC_RST;
        else if (take && alu_to_working)
            working <= alu_result;
    end

    // data memory, written at the addressed byte
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `MX_MEM_DEPTH; i++)
                mem[i] <= 8'h00;
        end
        else if (take && alu_to_memory && (mem_addr < 8'(`MX_MEM_DEPTH)))
            mem[mem_addr] <= alu_result;
    end

    // registered view of one memory byte
    always_ff @(posedge clk)
    begin
        if (rst)
            peek_data <= 8'h00;
        else
            peek_data <= (peek_addr < 8'(`MX_MEM_DEPTH)) ? mem[peek_addr] : 8'h00;
    end

    // arithmetic flags; an executed instruction wins over an outside load
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            zero_flag <= 1'b0;
            carry_flag <= 1'b0;
            aux_carry_flag <= 1'b0;
        end
        else if (take)
        begin
            if (alu_sets_zero)
                zero_flag <= (alu_result == 8'h00);
            if (alu_sets_carry)
                carry_flag <= alu_carry_out;
        end
        else if (flags_load)
        begin
            zero_flag <= flags_load_data[2];
            carry_flag <= flags_load_data[1];
            aux_carry_flag <= flags_load_data[0];
        end
    end

    // preclear record flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            first_seen <= 1'b0;
            second_seen <= 1'b0;
        end
        else if (pair_done)
        begin
            first_seen <= 1'b0;
            second_seen <= 1'b0;
        end
        else if (take && (opcode == mx_pkg::OP_PRECLEAR_FIRST))
            first_seen <= 1'b1;
        else if (take && (opcode == mx_pkg::OP_PRECLEAR_SECOND))
            second_seen <= 1'b1;
    end

    // watchdog and prescaler clear pulses
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            watchdog_clear <= 1'b0;
            prescaler_clear <= 1'b0;
        end
        else
        begin
            watchdog_clear <= wd_clear_now
                || (take && (opcode == mx_pkg::OP_HALT));
            prescaler_clear <= take && (opcode == mx_pkg::OP_HALT);
        end
    end

    // timeout flag: a timeout event wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            watchdog_timeout_flag <= `MX_TOF_RST;
        else if (timeout_event)
            watchdog_timeout_flag <= 1'b1;
        else if (wd_clear_now || (take && (opcode == mx_pkg::OP_HALT)))
            watchdog_timeout_flag <= 1'b0;
    end

    // power-down flag
    always_ff @(posedge clk)
    begin
        if (rst)
            powerdown_flag <= `MX_PDF_RST;
        else if (take && (opcode == mx_pkg::OP_HALT))
            powerdown_flag <= 1'b1;
        else if (wd_clear_now)
            powerdown_flag <= 1'b0;
    end

    // halt state and system clock gate
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            halted <= 1'b0;
            sys_clock_enable <= 1'b1;
        end
        else if (take && (opcode == mx_pkg::OP_HALT))
        begin
            halted <= 1'b1;
            sys_clock_enable <= 1'b0;
        end
        else if (wake)
        begin
            halted <= 1'b0;
            sys_clock_enable <= 1'b1;
        end
    end

    // global interrupt enable: the return sets it, a taken interrupt clears it
    always_ff @(posedge clk)
    begin
        if (rst)
            global_interrupt_enable <= `MX_GIE_RST;
        else if (take && (opcode == mx_pkg::OP_INTERRUPT_EXIT))
            global_interrupt_enable <= 1'b1;
        else if (interrupt_taken)
            global_interrupt_enable <= 1'b0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_clear_flags: assert property (
        take && opcode == mx_pkg::OP_WATCHDOG_CLEAR && !timeout_event
        |=> watchdog_clear && !watchdog_timeout_flag && !powerdown_flag)
        else $error("watchdog clear did not clear flags");

    chk_preclear_pair: assert property (
        take && opcode == mx_pkg::OP_PRECLEAR_SECOND && first_seen
        |=> watchdog_clear && !powerdown_flag)
        else $error("preclear pair did not clear");

    chk_preclear_single: assert property (
        take && opcode == mx_pkg::OP_PRECLEAR_FIRST && !second_seen
        |=> !watchdog_clear && $stable(powerdown_flag) && first_seen)
        else $error("single preclear changed watchdog state");

    chk_halt_entry: assert property (
        take && opcode == mx_pkg::OP_HALT
        |=> halted && !sys_clock_enable && pc == $past(pc) + 12'h001)
        else $error("halt did not stop execution");

    chk_halt_flags: assert property (
        take && opcode == mx_pkg::OP_HALT && !timeout_event
        |=> powerdown_flag && !watchdog_timeout_flag && prescaler_clear)
        else $error("halt flags wrong");

    chk_jump_target: assert property (
        take && opcode == mx_pkg::OP_JUMP
        |=> pc == $past(jump_addr) && $stable(zero_flag))
        else $error("jump target not loaded");

    chk_idle_only_pc: assert property (
        take && opcode == mx_pkg::OP_IDLE
        |=> $stable(working) && $stable(zero_flag) && pc == $past(pc) + 12'h001)
        else $error("idle changed state");

    chk_exit_two_cycles: assert property (
        take && is_exit |=> busy ##1 !busy)
        else $error("return did not take two cycles");

    chk_gie_set: assert property (
        take && opcode == mx_pkg::OP_INTERRUPT_EXIT |=> global_interrupt_enable)
        else $error("interrupt return did not enable interrupts");

    chk_zero_result: assert property (
        take && alu_sets_zero |=> zero_flag == ($past(alu_result) == 8'h00))
        else $error("zero flag does not match result");

    chk_rotate_working: assert property (
        take && opcode == mx_pkg::OP_ROTATE_LEFT_TO_WORKING
        |=> working == {$past(mem_rd[6:0]), $past(mem_rd[7])})
        else $error("rotate to working wrong");

endmodule

// >>> dv/tb.sv
/*
 * Self-checking bench for the execute subset: drives decoded instructions,
 * pushes and flag loads at the ports and checks registers and memory.
 * Assumes mx_exec_core with the constants header and mx_pkg compiled first.
 */
`timescale 1ns/1ps

module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        instr_valid = 1'b0;
    logic        push_valid = 1'b0;
    logic        flags_load = 1'b0;
    logic        timeout_event = 1'b0;
    logic        interrupt_taken = 1'b0;
    logic        wake = 1'b0;
    logic [7:0]  mem_addr = 8'h00;
    logic [7:0]  imm = 8'h00;
    logic [7:0]  peek_addr = 8'h00;
    logic [11:0] jump_addr = 12'h000;
    logic [11:0] push_addr = 12'h000;
    logic [2:0]  flags_load_data = 3'h0;
    logic        busy, halted, sys_clock_enable, zero_flag, carry_flag, aux_carry_flag;
    logic        watchdog_timeout_flag, powerdown_flag, global_interrupt_enable;
    logic        watchdog_clear, prescaler_clear;
    logic [11:0] pc;
    logic [7:0]  working, peek_data;
    int          errors = 0;
    int          compares = 0;
    mx_pkg::mx_op_e opcode = mx_pkg::OP_IDLE;
    logic [7:0]  da_acc [4] = '{8'h9a, 8'h45, 8'h12, 8'h12};
    logic [2:0]  da_flg [4] = '{3'h0, 3'h0, 3'h1, 3'h2};
    logic [7:0]  da_res [4] = '{8'h00, 8'h45, 8'h18, 8'h72};
    logic        da_c   [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    mx_exec_core DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid), .opcode(opcode),
        .mem_addr(mem_addr), .imm(imm), .jump_addr(jump_addr), .push_valid(push_valid),
        .push_addr(push_addr), .flags_load(flags_load), .flags_load_data(flags_load_data),
        .timeout_event(timeout_event), .interrupt_taken(interrupt_taken), .wake(wake),
        .peek_addr(peek_addr), .busy(busy), .halted(halted),
        .sys_clock_enable(sys_clock_enable), .pc(pc), .working(working),
        .zero_flag(zero_flag), .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag),
        .watchdog_timeout_flag(watchdog_timeout_flag), .powerdown_flag(powerdown_flag),
        .global_interrupt_enable(global_interrupt_enable), .watchdog_clear(watchdog_clear),
        .prescaler_clear(prescaler_clear), .peek_data(peek_data));

    // 125 MHz clock
    always #4 clk = ~clk;

    task give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one instruction: gap cycle, wait out busy, then one taking edge
    task exec(input mx_pkg::mx_op_e op, input logic [7:0] a, input logic [7:0] x);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (busy !== 1'b0 && n < 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 10)
        begin
            errors++;
            give_verdict();
        end
        instr_valid = 1'b1;
        opcode = op;
        mem_addr = a;
        imm = x;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
    endtask

    // memory byte through the peek port
    task rd(input logic [7:0] a, input logic [7:0] exp);
        peek_addr = a;
        @(posedge clk);
        #1;
        chk(peek_data, exp);
    endtask

    // push a return address in a cycle with no instruction
    task push(input logic [11:0] a);
        push_valid = 1'b1;
        push_addr = a;
        @(posedge clk);
        #1;
        push_valid = 1'b0;
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(pc, 12'h000);
        chk(sys_clock_enable, 1'b1);
        exec(mx_pkg::OP_COPY_IMM, 8'h00, 8'h00);
        exec(mx_pkg::OP_COPY_TO_MEM, 8'h05, 8'h00);
        exec(mx_pkg::OP_PLUS_ONE, 8'h05, 8'h00);
        chk(zero_flag, 1'b0);
        exec(mx_pkg::OP_PLUS_ONE_TO_WORKING, 8'h05, 8'h00);
        chk(working, 8'h02);
        rd(8'h05, 8'h01);
        exec(mx_pkg::OP_MINUS_ONE, 8'h05, 8'h00);
        chk(zero_flag, 1'b1);
        exec(mx_pkg::OP_MINUS_ONE_TO_WORKING, 8'h05, 8'h00);
        chk(working, 8'hff);
        chk(zero_flag, 1'b0);
        exec(mx_pkg::OP_COMPLEMENT, 8'h05, 8'h00);
        rd(8'h05, 8'hff);
        exec(mx_pkg::OP_COMPLEMENT_TO_WORKING, 8'h05, 8'h00);
        chk(working, 8'h00);
        chk(zero_flag, 1'b1);
        rd(8'h05, 8'hff);
        exec(mx_pkg::OP_COPY_IMM, 8'h00, 8'h81);
        chk(zero_flag, 1'b1);
        exec(mx_pkg::OP_COPY_TO_MEM, 8'h06, 8'h00);
        exec(mx_pkg::OP_ROTATE_LEFT, 8'h06, 8'h00);
        rd(8'h06, 8'h03);
        exec(mx_pkg::OP_ROTATE_LEFT_TO_WORKING, 8'h06, 8'h00);
        chk(working, 8'h06);
        exec(mx_pkg::OP_UNION_IMM, 8'h00, 8'h30);
        chk(working, 8'h36);
        chk(zero_flag, 1'b0);
        exec(mx_pkg::OP_UNION_TO_MEMORY, 8'h06, 8'h00);
        rd(8'h06, 8'h37);
        exec(mx_pkg::OP_UNION_MEM, 8'h06, 8'h00);
        chk(working, 8'h37);
        rd(8'h06, 8'h37);
        exec(mx_pkg::OP_COPY_FROM_MEM, 8'h05, 8'h00);
        chk(working, 8'hff);
        // decimal adjust table: working, flags, result, carry
        for (int i = 0; i < 4; i++)
        begin
            flags_load = 1'b1;
            flags_load_data = da_flg[i];
            @(posedge clk);
            #1;
            flags_load = 1'b0;
            exec(mx_pkg::OP_COPY_IMM, 8'h00, da_acc[i]);
            exec(mx_pkg::OP_DECIMAL_ADJUST, 8'h10, 8'h00);
            chk(carry_flag, da_c[i]);
            chk(aux_carry_flag, da_flg[i][0]);
            rd(8'h10, da_res[i]);
        end
        jump_addr = 12'h3a5;
        exec(mx_pkg::OP_JUMP, 8'h00, 8'h00);
        chk(pc, 12'h3a5);
        exec(mx_pkg::OP_IDLE, 8'h00, 8'h00);
        chk(pc, 12'h3a6);
        push(12'h123);
        exec(mx_pkg::OP_SUBROUTINE_EXIT, 8'h00, 8'h00);
        chk(pc, 12'h123);
        chk(busy, 1'b1);
        push(12'h456);
        exec(mx_pkg::OP_SUBROUTINE_EXIT_CONST, 8'h00, 8'h5a);
        chk(pc, 12'h456);
        chk(working, 8'h5a);
        push(12'h789);
        exec(mx_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00);
        chk(global_interrupt_enable, 1'b1);
        timeout_event = 1'b1;
        interrupt_taken = 1'b1;
        @(posedge clk);
        #1;
        timeout_event = 1'b0;
        interrupt_taken = 1'b0;
        chk(global_interrupt_enable, 1'b0);
        exec(mx_pkg::OP_PRECLEAR_FIRST, 8'h00, 8'h00);
        chk(watchdog_clear, 1'b0);
        chk(watchdog_timeout_flag, 1'b1);
        exec(mx_pkg::OP_PRECLEAR_SECOND, 8'h00, 8'h00);
        chk(watchdog_clear, 1'b1);
        chk(watchdog_timeout_flag, 1'b0);
        exec(mx_pkg::OP_HALT, 8'h00, 8'h00);
        chk({halted, sys_clock_enable, powerdown_flag}, 3'h5);
        chk({watchdog_clear, prescaler_clear}, 2'h3);
        chk(pc, 12'h78c);
        exec(mx_pkg::OP_JUMP, 8'h00, 8'h00);
        chk(pc, 12'h78c);
        wake = 1'b1;
        @(posedge clk);
        #1;
        wake = 1'b0;
        timeout_event = 1'b1;
        @(posedge clk);
        #1;
        timeout_event = 1'b0;
        exec(mx_pkg::OP_WATCHDOG_CLEAR, 8'h00, 8'h00);
        chk({watchdog_clear, watchdog_timeout_flag, powerdown_flag}, 3'h4);
        give_verdict();
    end
endmodule
